// ---- rnf_map.svh ----
`ifndef RNF_MAP_SVH
`define RNF_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RNF_CTRL_OFS      8'h00
`define RNF_STATUS_OFS    8'h04
`define RNF_STATNAME_OFS  8'h08
`define RNF_RXCHAR_OFS    8'h0c
`define RNF_RTEXT_OFS     8'h10
`define RNF_RTLEN_OFS     8'h14
`define RNF_AFDATA_OFS    8'h18
`define RNF_AFCNT_OFS     8'h1c

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define RNF_MODE_LSB      0
`define RNF_SPEED_LSB     4
`define RNF_RATE_LSB      8
`define RNF_HDR_BIT       12
`define RNF_IDX_LSB       8
`define RNF_SPEED_RST     4'h0
`define RNF_RATE_RST      4'h2
`define RNF_HDR_RST       1'b1

// ----------------------------------------------------------------
// sizes, characters and pacing counts
// ----------------------------------------------------------------
`define RNF_NAME_LEN      8
`define RNF_DYN_LEN       128
`define RNF_RT_LEN        64
`define RNF_AF_MAX        25
`define RNF_SLOTS         4'h9
`define RNF_SPEED_MAX     4'h9
`define RNF_RATE_MAX      4'h9
`define RNF_DWELL_TOP     5'h0a
`define RNF_SPACE         8'h20
`define RNF_CR            8'h0d
`define RNF_TOK0          8'h44
`define RNF_TOK1          8'h50
`define RNF_TOK2          8'h53
`define RNF_TOK3          8'h3d

`endif

// ---- rnf_pkg.sv ----
package rnf_pkg;
  `include "rnf_map.svh"

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PARSE_AUTO, PARSE_SINGLE, PARSE_BLOCK} rnf_parse_t;
  typedef enum logic [1:0] {RX_MATCH, RX_TEXT, RX_SKIP} rnf_rx_t;
  typedef enum logic [1:0] {KIND_STATIC, KIND_SCROLL, KIND_TEXT} rnf_kind_t;

  // ----------------------------------------------------------------
  // whole state of the formatter
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                                  waitReq;
    logic [31:0]                           rdData;
    logic [1:0]                            mode;
    logic [3:0]                            speed;
    logic [3:0]                            rate;
    logic                                  hdrMode;
    logic [`RNF_NAME_LEN-1:0][7:0]         stat;
    logic [`RNF_DYN_LEN-1:0][7:0]          dyn;
    logic [7:0]                            dynLen;
    logic [`RNF_RT_LEN-1:0][7:0]           rt;
    logic [6:0]                            rtLen;
    logic [`RNF_AF_MAX-1:0][7:0]           af;
    logic [4:0]                            afCnt;
    rnf_rx_t                               rx;
    logic [1:0]                            tokIdx;
    logic                                  fresh;
    logic [7:0]                            pos;
    logic [7:0]                            sub;
    logic [4:0]                            dwell;
    logic [3:0]                            slot;
    logic                                  txValid;
    rnf_kind_t                             txKind;
    logic [63:0]                           txName;
    logic [15:0]                           frameCnt;
  } rnf_state_t;
endpackage

// ---- rnf_cut_if.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// link between the formatter and its frame cutter
// ----------------------------------------------------------------
interface rnf_cut_if;
  logic [127:0][7:0]   text;
  logic [7:0]          len;
  logic [7:0]          pos;
  logic [7:0]          sub;
  rnf_pkg::rnf_parse_t mode;
  logic [63:0]         frame;
  logic [7:0]          nextPos;
  logic [7:0]          nextSub;
  logic                fast;

  modport owner (output text, len, pos, sub, mode, input frame, nextPos, nextSub, fast);
  modport cutter (input text, len, pos, sub, mode, output frame, nextPos, nextSub, fast);
endinterface

// ---- rnf_frame_cutter.sv ----
`timescale 1ns/1ps
`include "rnf_map.svh"
// ----------------------------------------------------------------
// cuts the display frame at the current position of the scroll text
// ----------------------------------------------------------------
module rnf_frame_cutter (
  // cutter side
  rnf_cut_if.cutter cut
);
  // character at an index, blank beyond the message end
  function automatic logic [7:0] chAt(input logic [127:0][7:0] t, input logic [7:0] n,
                                      input logic [8:0] i);
    chAt = (i < {1'b0, n}) ? t[i[6:0]] : `RNF_SPACE;
  endfunction

  logic [8:0] s;
  logic [8:0] w;
  logic [8:0] g;
  logic [8:0] start;
  logic [8:0] limit;
  logic [8:0] k;
  logic       found;
  logic       run;

  // word search, grouping and window selection
  always_comb begin
    s = {1'b0, cut.len};
    found = 1'b0;
    for (int i = 0; i < 128; i++) begin
      if (!found && 9'(i) >= {1'b0, cut.pos} && chAt(cut.text, cut.len, 9'(i)) != `RNF_SPACE) begin
        s = 9'(i);
        found = 1'b1;
      end
    end
    w = 9'h000;
    run = 1'b1;
    for (int i = 0; i < 128; i++) begin
      if (9'(i) >= s) begin
        if (run && chAt(cut.text, cut.len, 9'(i)) != `RNF_SPACE) begin
          w = w + 9'h001;
        end else begin
          run = 1'b0;
        end
      end
    end
    g = s + w;
    for (int j = 1; j <= 8; j++) begin
      k = s + 9'(j);
      if (k <= {1'b0, cut.len} && chAt(cut.text, cut.len, k) == `RNF_SPACE &&
          chAt(cut.text, cut.len, k - 9'h001) != `RNF_SPACE) begin
        g = k;
      end
    end
    start = {1'b0, cut.pos};
    limit = 9'h1ff;
    cut.fast = 1'b0;
    cut.nextSub = 8'h00;
    cut.nextPos = cut.pos;
    unique case (cut.mode)
      rnf_pkg::PARSE_AUTO: begin
        if (w > 9'h008) begin
          start = s + {1'b0, cut.sub};
          cut.fast = 1'b1;
          if ({1'b0, cut.sub} + 9'h008 >= w) begin
            cut.nextPos = 8'(s + w);
          end else begin
            cut.nextSub = cut.sub + 8'h01;
          end
        end else begin
          start = s;
          limit = g;
          cut.nextPos = 8'(g);
        end
      end
      rnf_pkg::PARSE_SINGLE: begin
        cut.nextPos = cut.pos + 8'h01;
      end
      default: begin
        cut.nextPos = cut.pos + 8'h08;
      end
    endcase
    for (int b = 0; b < 8; b++) begin
      k = start + 9'(b);
      cut.frame[63-8*b -: 8] = (k >= limit) ? `RNF_SPACE : chAt(cut.text, cut.len, k);
    end
  end
endmodule // rnf_frame_cutter

// ---- rnf_name_text_formatter.sv ----
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "rnf_map.svh"
module rnf_name_text_formatter (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // register bus
  input  wire logic [7:0]   avsAddress,
  input  wire logic         avsRead,
  input  wire logic         avsWrite,
  input  wire logic [31:0]  avsWriteData,
  input  wire logic [3:0]   avsByteEnable,
  output logic      [31:0]  avsReadData,
  output logic              avsWaitRequest,
  // frames to the group generator
  input  wire logic         txReady,
  output logic              txValid,
  output logic      [1:0]   txKind,
  output logic      [63:0]  txName,
  output logic      [511:0] txText,
  output logic      [6:0]   txTextLen,
  // alternative frequency list
  output logic      [199:0] afList,
  output logic      [4:0]   afCount
);
  rnf_pkg::rnf_state_t q;
  rnf_pkg::rnf_state_t d;
  rnf_cut_if           cut ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // settings above nine are held at nine
  function automatic logic [3:0] clampNine(input logic [3:0] v);
    clampNine = (v > `RNF_SPEED_MAX) ? `RNF_SPEED_MAX : v;
  endfunction

  // slots a frame stays up: larger speed gives shorter dwell
  function automatic logic [4:0] dwellOf(input logic [3:0] sp, input logic fast);
    logic [4:0] base;
    base = `RNF_DWELL_TOP - {1'b0, sp};
    dwellOf = fast ? (base - {2'b00, base[4:2]}) : base;
  endfunction

  // header token, one character per index
  function automatic logic [7:0] tokAt(input logic [1:0] i);
    unique case (i)
      2'd0: tokAt = `RNF_TOK0;
      2'd1: tokAt = `RNF_TOK1;
      2'd2: tokAt = `RNF_TOK2;
      default: tokAt = `RNF_TOK3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // frame cutter
  // ----------------------------------------------------------------
  // the cutter sees the live buffer and scroll position
  assign cut.text = q.dyn;
  assign cut.len  = q.dynLen;
  assign cut.pos  = q.pos;
  assign cut.sub  = q.sub;
  assign cut.mode = (q.mode == 2'd0) ? rnf_pkg::PARSE_AUTO :
                    (q.mode == 2'd1) ? rnf_pkg::PARSE_SINGLE : rnf_pkg::PARSE_BLOCK;

  // cutter is pure logic; the scheduler registers its frame
  rnf_frame_cutter u_cutter (
    .cut (cut.cutter)
  );

  // scratch values of the next-state logic
  logic [31:0] wd;
  logic        wrHit;
  logic        rdHit;
  logic [7:0]  ch;
  logic [7:0]  np;
  logic        sendText;
  logic        restart; // scroll must start again from the top

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // disabled byte lanes write zero
    wd = avsWriteData & {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}},
                         {8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
    ch = wd[7:0];
    // one wait cycle, then the access completes
    d.waitReq = !((avsRead || avsWrite) && q.waitReq);
    // writes land on the edge that sees waitrequest low
    wrHit = avsWrite && !q.waitReq;
    rdHit = avsRead && q.waitReq;
    np = 8'h00;
    sendText = 1'b0;
    restart = 1'b0;

    // read mux, sampled on the first cycle of the access
    // unmapped and write-only offsets read as zero
    if (rdHit) begin
      unique case (avsAddress)
        `RNF_CTRL_OFS:   d.rdData = {19'h0, q.hdrMode, q.rate, q.speed, 2'b00, q.mode};
        `RNF_STATUS_OFS: d.rdData = {q.frameCnt, q.dynLen, q.pos};
        `RNF_RTLEN_OFS:  d.rdData = {25'h0, q.rtLen};
        `RNF_AFCNT_OFS:  d.rdData = {27'h0, q.afCnt};
        default:         d.rdData = 32'h0000_0000;
      endcase
    end

    // register writes
    if (wrHit) begin
      unique case (avsAddress)
        `RNF_CTRL_OFS: begin
          // a control write rewinds the scroll and the header matcher
          d.mode = wd[`RNF_MODE_LSB +: 2];
          d.speed = clampNine(wd[`RNF_SPEED_LSB +: 4]);
          d.rate = clampNine(wd[`RNF_RATE_LSB +: 4]);
          d.hdrMode = wd[`RNF_HDR_BIT];
          d.rx = wd[`RNF_HDR_BIT] ? rnf_pkg::RX_MATCH : rnf_pkg::RX_TEXT;
          d.tokIdx = 2'd0;
          d.fresh = 1'b1;
          restart = 1'b1;
          d.pos = 8'h00;
          d.sub = 8'h00;
          d.dwell = 5'h00;
        end
        `RNF_STATNAME_OFS: begin
          // character 0 lands in the top byte, shown first
          d.stat[3'h7 - wd[`RNF_IDX_LSB +: 3]] = ch;
        end
        `RNF_RTEXT_OFS: begin
          // radio text is kept whole and never parsed
          d.rt[6'(wd[`RNF_IDX_LSB +: 6])] = ch;
        end
        `RNF_RTLEN_OFS: begin
          // length clamps at the text size
          d.rtLen = (wd[6:0] > 7'd64) ? 7'd64 : wd[6:0];
        end
        `RNF_AFDATA_OFS: begin
          // entries past the last slot are ignored
          if (wd[`RNF_IDX_LSB +: 5] < 5'(`RNF_AF_MAX)) begin
            d.af[wd[`RNF_IDX_LSB +: 5]] = ch;
          end
        end
        `RNF_AFCNT_OFS: begin
          // count clamps at the list size
          d.afCnt = (wd[4:0] > 5'(`RNF_AF_MAX)) ? 5'(`RNF_AF_MAX) : wd[4:0];
        end
        `RNF_RXCHAR_OFS: begin
          if (ch == `RNF_CR) begin
            // line end closes the transfer; buffer keeps repeating it
            d.rx = q.hdrMode ? rnf_pkg::RX_MATCH : rnf_pkg::RX_TEXT;
            d.tokIdx = 2'd0;
            d.fresh = 1'b1;
          end else begin
            unique case (q.rx)
              rnf_pkg::RX_MATCH: begin
                // header token must arrive whole at line start
                if (ch == tokAt(q.tokIdx)) begin
                  d.tokIdx = q.tokIdx + 2'd1;
                  if (q.tokIdx == 2'd3) begin
                    d.rx = rnf_pkg::RX_TEXT;
                    d.fresh = 1'b1;
                  end
                end else begin
                  d.rx = rnf_pkg::RX_SKIP;
                end
              end
              rnf_pkg::RX_TEXT: begin
                if (q.fresh) begin
                  // first character of a transfer wipes the old message
                  d.dyn = {`RNF_DYN_LEN{`RNF_SPACE}};
                  d.dyn[0] = ch;
                  d.dynLen = 8'h01;
                  d.fresh = 1'b0;
                  restart = 1'b1;
                  d.pos = 8'h00;
                  d.sub = 8'h00;
                  d.dwell = 5'h00;
                end else if (q.dynLen < 8'(`RNF_DYN_LEN)) begin
                  d.dyn[q.dynLen[6:0]] = ch;
                  d.dynLen = q.dynLen + 8'h01;
                end
              end
              default: begin
                // refused line: drop the rest until its end
                d.rx = rnf_pkg::RX_SKIP;
              end
            endcase
          end
        end
        default: begin
          d.rdData = q.rdData;
        end
      endcase
    end

    // frame scheduler: one slot per frame the generator takes
    // the generator's ready retires the offered frame
    if (q.txValid && txReady) begin
      d.txValid = 1'b0;
    end
    // each new offer takes the next of ten slots, text slots first
    if (!q.txValid) begin
      d.txValid = 1'b1;
      d.frameCnt = q.frameCnt + 16'h0001;
      d.slot = (q.slot == `RNF_SLOTS) ? 4'h0 : q.slot + 4'h1;
      sendText = (q.rate != 4'h0) && (q.slot < q.rate);
      if (sendText) begin
        d.txKind = rnf_pkg::KIND_TEXT;
      end else if (q.speed == 4'h0 || q.dynLen == 8'h00) begin
        // scrolling off or nothing loaded
        d.txKind = rnf_pkg::KIND_STATIC;
        d.txName = q.stat;
      end else begin
        d.txKind = rnf_pkg::KIND_SCROLL;
        d.txName = cut.frame;
        if (q.dwell <= 5'h01) begin
          // dwell spent in scroll slots only, so text slots slow scrolling
          np = (cut.nextPos >= q.dynLen) ? 8'h00 : cut.nextPos;
          d.pos = np;
          d.sub = (cut.nextPos >= q.dynLen) ? 8'h00 : cut.nextSub;
          d.dwell = dwellOf(q.speed, cut.fast);
        end else begin
          d.dwell = q.dwell - 5'h01;
        end
        // zero dwell marks a fresh start: hold this frame a full dwell
        if (q.dwell == 5'h00) begin
          d.dwell = dwellOf(q.speed, cut.fast);
          d.pos = q.pos;
          d.sub = q.sub;
        end
      end
    end
    // a control write or a new message beats the scheduler's step
    if (restart) begin
      d.pos = 8'h00;
      d.sub = 8'h00;
      d.dwell = 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset leaves blanks wherever text can show
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.waitReq <= 1'b1;
      q.speed <= `RNF_SPEED_RST;
      q.rate <= `RNF_RATE_RST;
      q.hdrMode <= `RNF_HDR_RST;
      q.stat <= {`RNF_NAME_LEN{`RNF_SPACE}};
      q.dyn <= {`RNF_DYN_LEN{`RNF_SPACE}};
      q.rt <= {`RNF_RT_LEN{`RNF_SPACE}};
      q.rx <= rnf_pkg::RX_MATCH;
      q.txKind <= rnf_pkg::KIND_STATIC;
      q.txName <= {`RNF_NAME_LEN{`RNF_SPACE}};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from the state register
  // ----------------------------------------------------------------
  assign avsReadData    = q.rdData;
  assign avsWaitRequest = q.waitReq;
  assign txValid        = q.txValid;
  assign txKind         = q.txKind;
  assign txName         = q.txName;
  assign txText         = q.rt;
  assign txTextLen      = q.rtLen;
  assign afList         = q.af;
  assign afCount        = q.afCnt;
endmodule // rnf_name_text_formatter

// ---- rnf_name_text_formatter_assertions.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the formatter
// ----------------------------------------------------------------
module rnf_name_text_formatter_assertions (
  // clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // register bus
  input wire logic [7:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  // frame stream and frequency list
  input wire logic        txReady,
  input wire logic        txValid,
  input wire logic [1:0]  txKind,
  input wire logic [63:0] txName,
  input wire logic [6:0]  txTextLen,
  input wire logic [4:0]  afCount
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // bus answers with exactly one wait cycle
  property p_waitOnce;
    !avsWaitRequest |=> avsWaitRequest;
  endproperty
  a_waitOnce: assert property (p_waitOnce)
    else $error("waitrequest low for more than one cycle");
  property p_answer;
    (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered in the next cycle");
  property p_noUnasked;
    !avsWaitRequest |-> $past(avsRead || avsWrite);
  endproperty
  a_noUnasked: assert property (p_noUnasked)
    else $error("waitrequest dropped without a request");
  // unmapped offsets read as zero
  property p_unmapped;
    avsRead && !avsWaitRequest && (avsAddress[1:0] != 2'h0 || avsAddress > 8'h1c)
      |-> avsReadData == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned nonzero data");
  // frame held until taken, then one idle cycle
  property p_hold;
    txValid && !txReady |=> txValid && $stable(txName) && $stable(txKind);
  endproperty
  a_hold: assert property (p_hold)
    else $error("frame changed before acceptance");
  property p_gap;
    txValid && txReady |=> !txValid ##1 txValid;
  endproperty
  a_gap: assert property (p_gap)
    else $error("next frame not offered after one idle cycle");
  property p_kind;
    txValid |-> txKind != 2'h3;
  endproperty
  a_kind: assert property (p_kind)
    else $error("illegal frame kind");
  // list and text bounds, and list count moves only on its write
  property p_afMax;
    afCount <= 5'd25;
  endproperty
  a_afMax: assert property (p_afMax)
    else $error("frequency count above 25");
  property p_afCause;
    afCount != $past(afCount) |-> $past(avsWrite && !avsWaitRequest && avsAddress == 8'h1c);
  endproperty
  a_afCause: assert property (p_afCause)
    else $error("frequency count changed without a write");
  property p_rtMax;
    txTextLen <= 7'd64;
  endproperty
  a_rtMax: assert property (p_rtMax)
    else $error("radio text length above 64");
endmodule // rnf_name_text_formatter_assertions

bind rnf_name_text_formatter rnf_name_text_formatter_assertions chk (.clock, .nrst,
  .avsAddress, .avsRead, .avsWrite, .avsReadData, .avsWaitRequest, .txReady,
  .txValid, .txKind, .txName, .txTextLen, .afCount);

// ---- rnf_group_sink.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// downstream group generator, ready one cycle in three
// ----------------------------------------------------------------
module rnf_group_sink (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // frames from the formatter
  input  wire logic        txValid,
  input  wire logic [1:0]  txKind,
  input  wire logic [63:0] txName,
  output logic             txReady,
  // frame offered one cycle earlier; got pulses one cycle per accepted frame
  output logic             got,
  output logic      [1:0]  gotKind,
  output logic      [63:0] gotName
);
  logic [1:0] phase;

  // stalls two cycles of three so frames must wait
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase   <= 2'h0;
      txReady <= 1'b0;
      got     <= 1'b0;
      gotKind <= 2'h0;
      gotName <= 64'h0;
    end else begin
      phase   <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      txReady <= (phase == 2'h1);
      got     <= txValid && txReady;
      gotKind <= txKind;
      gotName <= txName;
    end
  end
endmodule // rnf_group_sink

// ---- rnf_name_text_formatter_bench.sv ----
`timescale 1ns/1ps
`include "rnf_map.svh"
module rnf_name_text_formatter_bench;
  // ----------------------------------------------------------------
  // stimulus, wiring and helpers
  // ----------------------------------------------------------------
  logic         clock = 1'b0;
  logic         nrst = 1'b0;
  logic [7:0]   avsAddress = 8'h00;
  logic         avsRead = 1'b0;
  logic         avsWrite = 1'b0;
  logic [31:0]  avsWriteData = 32'h0;
  logic [3:0]   avsByteEnable = 4'h0;
  logic [31:0]  avsReadData, q;
  logic         avsWaitRequest, txReady, txValid, got;
  logic [1:0]   txKind, gotKind;
  logic [63:0]  txName, gotName;
  logic [511:0] txText;
  logic [6:0]   txTextLen;
  logic [199:0] afList;
  logic [4:0]   afCount;
  int           errCount = 0;
  int           compares = 0;

  always #25 clock = ~clock;

  rnf_name_text_formatter dut (.clock, .nrst, .avsAddress, .avsRead, .avsWrite,
    .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest, .txReady, .txValid,
    .txKind, .txName, .txText, .txTextLen, .afList, .afCount);
  rnf_group_sink sink (.clock, .nrst, .txValid, .txKind, .txName, .txReady, .got,
    .gotKind, .gotName);

  task tallyAndFinish;
    $display("compares %0d, mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one access held until waitrequest is sampled low at a rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    avsAddress    <= a;
    avsWrite      <= wr;
    avsRead       <= !wr;
    avsWriteData  <= d;
    avsByteEnable <= 4'hf;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      check("bus answer", 64'h0, 64'h1);
      tallyAndFinish();
    end
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    @(negedge clock);
  endtask

  task ctrl(input logic hdr, input logic [3:0] rate, input logic [3:0] spd, input logic [1:0] m);
    bus(1'b1, `RNF_CTRL_OFS, {19'h0, hdr, rate, spd, 2'h0, m});
  endtask

  task sendText(input string s);
    for (int i = 0; i < s.len(); i++) begin
      bus(1'b1, `RNF_RXCHAR_OFS, {24'h0, s[i]});
    end
    bus(1'b1, `RNF_RXCHAR_OFS, {24'h0, `RNF_CR});
  endtask

  task nextFrame;
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (got !== 1'b1 && n < 100);
    if (n >= 100) begin
      check("frame arrival", 64'h0, 64'h1);
      tallyAndFinish();
    end
  endtask

  // waits for the scroll frame e[3], then checks the three following distinct frames
  task scrollSeq(input logic [1:0] m, input string s, input logic [3:0][63:0] e);
    logic [63:0] prev;
    ctrl(1'b0, 4'h0, 4'h6, m);
    sendText(s);
    for (int n = 0; n < 300 && !(gotKind === 2'h1 && gotName === e[3]); n++) begin
      nextFrame();
    end
    check("first scroll frame", gotName, e[3]);
    for (int k = 2; k >= 0; k--) begin
      prev = gotName;
      for (int n = 0; n < 100 && !(gotKind === 2'h1 && gotName !== prev); n++) begin
        nextFrame();
      end
      check("next scroll frame", gotName, e[k]);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task testReset;
    nextFrame();
    check("first frame kind", gotKind, 2'h2);
    repeat (2) nextFrame();
    check("reset frame kind", gotKind, 2'h0);
    check("reset frame name", gotName, "        ");
    check("reset frequency count", afCount, 5'h0);
    bus(1'b0, 8'h20, 32'h0);
    check("unmapped read", q, 32'h0);
    $display("test reset done");
  endtask

  task testModes;
    scrollSeq(2'h2, "ABCDEFGHIJKL", {"ABCDEFGH", "IJKL    ", "ABCDEFGH", "IJKL    "});
    scrollSeq(2'h1, "ABCDEFGHIJKLMNOP", {"ABCDEFGH", "BCDEFGHI", "CDEFGHIJ", "DEFGHIJK"});
    scrollSeq(2'h0, "THIS IS WARNING EMERGENCY", {"THIS IS ", "WARNING ", "EMERGENC", "MERGENCY"});
    $display("test modes done");
  endtask

  task testLoad;
    ctrl(1'b0, 4'h0, 4'h6, 2'h2);
    for (int i = 0; i < 128; i++) begin
      bus(1'b1, `RNF_RXCHAR_OFS, {24'h0, 8'h41 + 8'(i % 8)});
    end
    bus(1'b1, `RNF_RXCHAR_OFS, {24'h0, `RNF_CR});
    bus(1'b0, `RNF_STATUS_OFS, 32'h0);
    check("full buffer length", q[15:8], 8'h80);
    ctrl(1'b1, 4'h0, 4'h6, 2'h2);
    sendText("XY");
    bus(1'b1, `RNF_RXCHAR_OFS, {24'h0, `RNF_TOK0});
    bus(1'b1, `RNF_RXCHAR_OFS, {24'h0, `RNF_TOK1});
    bus(1'b1, `RNF_RXCHAR_OFS, {24'h0, `RNF_TOK2});
    bus(1'b1, `RNF_RXCHAR_OFS, {24'h0, `RNF_TOK3});
    sendText("HELLO");
    bus(1'b0, `RNF_STATUS_OFS, 32'h0);
    check("header message length", q[15:8], 8'h05);
    scrollSeq(2'h2, "", {"HELLO   ", "HELLO   ", "HELLO   ", "HELLO   "});
    $display("test load done");
  endtask

  task testRate;
    int rates[3] = '{0, 2, 9};
    int cnt;
    bus(1'b1, `RNF_RTEXT_OFS, {18'h0, 6'h0, 8'h52});
    bus(1'b1, `RNF_RTEXT_OFS, {18'h0, 6'h1, 8'h44});
    bus(1'b1, `RNF_RTLEN_OFS, 32'h2);
    check("radio text length", txTextLen, 7'h02);
    check("radio text chars", txText[15:0], "DR");
    for (int r = 0; r < 3; r++) begin
      ctrl(1'b1, 4'(rates[r]), 4'h6, 2'h2);
      repeat (12) nextFrame();
      cnt = 0;
      repeat (10) begin
        nextFrame();
        cnt += (gotKind === 2'h2);
      end
      check("text slots in ten", cnt, rates[r]);
    end
    $display("test rate done");
  endtask

  task testStatic;
    string s = "STATION1";
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `RNF_STATNAME_OFS, {21'h0, i[2:0], s[i]});
    end
    ctrl(1'b1, 4'h0, 4'h0, 2'h2);
    repeat (3) nextFrame();
    repeat (10) begin
      nextFrame();
      check("fixed name kind", gotKind, 2'h0);
      check("fixed name", gotName, "STATION1");
    end
    $display("test static done");
  endtask

  task testAf;
    bus(1'b1, `RNF_AFDATA_OFS, {19'h0, 5'd0, 8'h05});
    bus(1'b1, `RNF_AFDATA_OFS, {19'h0, 5'd24, 8'h24});
    bus(1'b1, `RNF_AFDATA_OFS, {19'h0, 5'd25, 8'h77});
    bus(1'b1, `RNF_AFCNT_OFS, 32'h2);
    check("frequency count", afCount, 5'd2);
    check("first and last entry", {afList[199:192], afList[7:0]}, 16'h2405);
    bus(1'b1, `RNF_AFCNT_OFS, 32'd30);
    check("frequency count clamp", afCount, 5'd25);
    $display("test frequencies done");
  endtask

  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    testReset();
    testModes();
    testLoad();
    testRate();
    testStatic();
    testAf();
    tallyAndFinish();
  end
endmodule // rnf_name_text_formatter_bench
